// ===== rtl/pbcr_pkg.sv
// Contract
// - 16-bit capability identifier in header bits 15:0, reset zero, lock-protected; 0x4 means budgeting.
// - 4-bit capability version in header bits 19:16, reset zero, lock-protected.
// - 8-bit writable select field, bits 7:0, reset zero, picks readout word.
// - select above seven makes the readout return all zeros.
// - readout register is read-only, returns the selected stored word for 0..7.
// - eight stored words accept writes only while the unlock bit is set.
package pbcr_pkg;
  localparam logic [11:0] PBCR_OFF_HEADER   = 12'h280;
  localparam logic [11:0] PBCR_OFF_SELECT   = 12'h284;
  localparam logic [11:0] PBCR_OFF_READOUT  = 12'h288;
  localparam logic [11:0] PBCR_OFF_WORD0    = 12'h300;
  localparam logic [11:0] PBCR_OFF_WORD7    = 12'h31C;
  localparam logic [11:0] PBCR_OFF_CONTROL  = 12'h404;
  localparam int          PBCR_NUM_WORDS    = 8;
  localparam logic [7:0]  PBCR_SEL_MAX      = 8'h07;
  localparam logic [31:0] PBCR_HEADER_RST   = 32'h0000_0000;
  localparam logic [7:0]  PBCR_SELECT_RST   = 8'h00;
  localparam logic [31:0] PBCR_WORD_RST     = 32'h0000_0000;
  localparam int          PBCR_CTL_WUNLOCK  = 0;
  localparam int          PBCR_CTL_HUNLOCK  = 1;

  typedef struct packed {
    logic [11:0] next_capability_pointer;
    logic [3:0]  capability_version;
    logic [15:0] capability_identifier;
  } pbcr_header_t;

  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } pbcr_req_t;
endpackage : pbcr_pkg

// ===== rtl/pbcr_word_store.sv
`timescale 1ns/1ps
`default_nettype none
module pbcr_word_store
  import pbcr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        wr_en,
  input  wire logic [2:0]  wr_idx,
  input  wire logic [31:0] wr_data,
  input  wire logic        budget_word_unlock,
  input  wire logic [7:0]  value_select_field,
  input  wire logic [2:0]  rd_idx,
  output logic      [31:0] rd_word,
  output logic      [31:0] power_budget_readout
);
  logic [31:0] stored_budget_word [PBCR_NUM_WORDS];

  // sticky in the real part; here a plain reset keeps sim free of x
  genvar g;
  for (g = 0; g < PBCR_NUM_WORDS; g++) begin : g_word
    always_ff @(posedge clk) begin
      if (!nrst) begin
        stored_budget_word[g] <= PBCR_WORD_RST;
      end else if (wr_en && budget_word_unlock && wr_idx == 3'(g)) begin
        stored_budget_word[g] <= wr_data;
      end
    end
  end

  assign rd_word = stored_budget_word[rd_idx];

  always_comb begin
    if (value_select_field > PBCR_SEL_MAX) begin
      power_budget_readout = 32'h0000_0000;
    end else begin
      power_budget_readout = stored_budget_word[value_select_field[2:0]];
    end
  end
endmodule : pbcr_word_store
`default_nettype wire

// ===== rtl/pbcr_regs.sv
`timescale 1ns/1ps
`default_nettype none
module pbcr_regs
  import pbcr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [11:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  input  wire logic        loader_wr,
  input  wire logic [31:0] loader_header,
  output logic      [7:0]  value_select_out
);
  pbcr_header_t header_reg;
  logic [7:0]   select_reg;
  logic [1:0]   control_reg;
  logic [31:0]  rdata_reg;
  logic [31:0]  readout;
  logic [31:0]  word_rd;
  logic         word_hit;

  assign word_hit = (addr >= PBCR_OFF_WORD0) && (addr <= PBCR_OFF_WORD7) && (addr[1:0] == 2'h0);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      control_reg <= 2'h0;
    end else if (wr && addr == PBCR_OFF_CONTROL) begin
      control_reg <= wdata[1:0];
    end
  end

  // loader wins over a bus write in the same cycle
  always_ff @(posedge clk) begin
    if (!nrst) begin
      header_reg <= PBCR_HEADER_RST;
    end else if (loader_wr) begin
      header_reg <= loader_header;
    end else if (wr && addr == PBCR_OFF_HEADER && control_reg[PBCR_CTL_HUNLOCK]) begin
      header_reg <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      select_reg <= PBCR_SELECT_RST;
    end else if (wr && addr == PBCR_OFF_SELECT) begin
      select_reg <= wdata[7:0];
    end
  end

  assign value_select_out = select_reg;

  pbcr_word_store u_store (
    .clk                  (clk),
    .nrst                 (nrst),
    .wr_en                (wr && word_hit),
    .wr_idx               (addr[4:2]),
    .wr_data              (wdata),
    .budget_word_unlock   (control_reg[PBCR_CTL_WUNLOCK]),
    .value_select_field   (select_reg),
    .rd_idx               (addr[4:2]),
    .rd_word              (word_rd),
    .power_budget_readout (readout)
  );

  // unmapped reads return zero; data only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata_reg <= 32'h0000_0000;
    end else if (!rd) begin
      rdata_reg <= 32'h0000_0000;
    end else if (addr == PBCR_OFF_HEADER) begin
      rdata_reg <= header_reg;
    end else if (addr == PBCR_OFF_SELECT) begin
      rdata_reg <= {24'h000000, select_reg};
    end else if (addr == PBCR_OFF_READOUT) begin
      rdata_reg <= readout;
    end else if (word_hit) begin
      rdata_reg <= word_rd;
    end else if (addr == PBCR_OFF_CONTROL) begin
      rdata_reg <= {30'h0, control_reg};
    end else begin
      rdata_reg <= 32'h0000_0000;
    end
  end

  assign rdata = rdata_reg;
endmodule : pbcr_regs
`default_nettype wire

// ===== tb/pbcr_props.sv
`timescale 1ns/1ps
`default_nettype none
module pbcr_props (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic        loader_wr,
  input wire logic [11:0] addr,
  input wire logic [31:0] wdata,
  input wire logic [31:0] rdata,
  input wire logic [31:0] loader_header,
  input wire logic [7:0]  value_select_out
);
  // shadow of both unlock bits, only to judge the lock checks
  logic [1:0] ul_reg;
  always_ff @(posedge clk) if (!nrst) ul_reg <= 2'h0;
    else if (wr && addr == 12'h404) ul_reg <= wdata[1:0];
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_lock(a, b);
    rd && addr == a ##1 wr && addr == a && !b && !loader_wr ##1 rd && addr == a;
  endsequence
  chk_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0) else $error("idle");
  chk_sel_wr: assert property (wr && addr == 12'h284 |=>
    value_select_out == $past(wdata[7:0])) else $error("sel wr");
  chk_sel_hold: assert property (!(wr && addr == 12'h284) |=>
    $stable(value_select_out)) else $error("sel moved");
  chk_sel_rd: assert property (rd && addr == 12'h284 |=>
    rdata == {24'h0, $past(value_select_out)}) else $error("sel rd");
  chk_sel_zero: assert property (rd && addr == 12'h288 && value_select_out > 8'h07 |=>
    rdata == 32'h0) else $error("readout");
  chk_loader_hdr: assert property (loader_wr ##1 rd && addr == 12'h280 |=>
    rdata == $past(loader_header, 2)) else $error("loader");
  chk_hdr_lock: assert property (s_lock(12'h280, ul_reg[1]) |=>
    rdata == $past(rdata, 2)) else $error("hdr lock");
  chk_word_lock: assert property (s_lock(12'h300, ul_reg[0]) |=>
    rdata == $past(rdata, 2)) else $error("word lock");
endmodule : pbcr_props
bind pbcr_regs pbcr_props u_pbcr_props (.*);
`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk = 0, nrst = 0, wr = 0, rd = 0, loader_wr = 0, rd_q = 0;
  logic [11:0] addr = 0;
  logic [31:0] wdata = 0, loader_header = 0, rdata, exp_n = 0, exp_q = 0;
  logic [7:0]  value_select_out, sel_n = 0, sel_q = 0;
  int          error_cnt, num_checks, m_w [8], m_h, m_s, m_u;
  pbcr_regs u_pbcr_regs (.clk, .nrst, .addr, .wdata, .wr, .rd, .rdata,
    .loader_wr, .loader_header, .value_select_out);
  initial forever #5 clk = ~clk;
  // select shadow lags one edge, like the register it mirrors
  always @(posedge clk) {rd_q, exp_q, sel_q} <= {rd, exp_n, sel_n};
  always @(negedge clk) if (nrst) begin
    chk(rdata, rd_q ? exp_q : 32'h0);
    chk(value_select_out, sel_q);
  end
  function automatic logic [31:0] mexp(input logic [11:0] a);
    if (a == 12'h280) return m_h;
    if (a == 12'h284) return m_s;
    if (a == 12'h288) return m_s > 7 ? 0 : m_w[m_s];
    if (a == 12'h404) return m_u;
    return a[11:5] == 7'h18 ? m_w[a[4:2]] : 0;
  endfunction : mexp
  function automatic logic [11:0] ad(input int i);
    return i < 3 ? 12'(12'h280 + 4 * i) : 12'(12'h2F4 + 4 * i);
  endfunction : ad
  task automatic bus(input logic w, r, l, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    {wr, rd, loader_wr, addr, wdata, loader_header} <= {w, r, l, a, d, d};
    exp_n <= mexp(a);
    if (l || (w && a == 12'h280 && m_u[1])) m_h = d;
    if (w && a == 12'h404) m_u = d[1:0];
    if (w && a == 12'h284) m_s = d[7:0];
    if (w && a[11:5] == 7'h18 && m_u[0]) m_w[a[4:2]] = d;
    sel_n <= 8'(m_s);
  endtask : bus
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report;
    if (error_cnt == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report
  initial begin
    void'($urandom(59));
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    // round 0 reads see reset values, later rounds each lock mix
    for (int r = 0; r < 5; r++) begin
      bus(1, 0, 0, 12'h404, r % 4);
      bus(0, 1, 0, 12'h404, 0);
      for (int i = 0; i < 11; i++) bus(0, 1, 0, ad(i), 0);
      for (int i = 0; i < 11; i++) bus(1, 0, 0, ad(i), $urandom);
    end
    for (int s = 0; s < 12; s++) begin
      bus(1, 0, 0, 12'h284, s < 10 ? s : $urandom);
      bus(0, 1, 0, 12'h288, 0);
    end
    bus(0, 0, 1, 0, $urandom);
    for (int i = 0; i < 7; i++)
      bus(i % 3 == 2, i % 3 != 2, 0, i < 4 ? 12'h280 : 12'h300, $urandom);
    bus(0, 0, 0, 0, 0);
    repeat (2) @(posedge clk);
    final_report();
  end
  initial begin
    #5us;
    error_cnt++;
    final_report();
  end
endmodule : testbench
`default_nettype wire
